// ==== pkg/gfc_params.svh ====
`ifndef GFC_PARAMS_SVH
`define GFC_PARAMS_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define GFC_IDX_FIFO_A      8'h1C
`define GFC_IDX_FIFO_B      8'h1D
`define GFC_IDX_END_32      8'h1E
`define GFC_IDX_END_54      8'h1F
`define GFC_IDX_END_6       8'h20
`define GFC_IDX_PENDING     8'h21
`define GFC_IDX_WAKE        8'h22
`define GFC_IDX_STATUS      8'h24
`define GFC_IDX_CLOCK       8'h26

// ****************************************************************
// field positions
// ****************************************************************
`define GFC_RETRY_HI        7
`define GFC_RETRY_LO        6
`define GFC_SLOT_HI         5
`define GFC_SLOT_LO         3
`define GFC_ACK_BIT         2
`define GFC_SEC_BIT         1
`define GFC_SEND_BIT        0
`define GFC_SPACE_HI        7
`define GFC_SPACE_LO        2
`define GFC_ALT_BIT         1
`define GFC_ACK_PENDING_FLAG_BIT       0
`define GFC_IMM_BIT         7
`define GFC_REGISTER_WAKE_PULSE_BIT     6
`define GFC_CLKON_BIT       3
`define GFC_NOTIME_B_BIT    4
`define GFC_NOTIME_A_BIT    3
`define GFC_FAIL_B_BIT      2
`define GFC_FAIL_A_BIT      1

// ****************************************************************
// reset values and fixed slots
// ****************************************************************
`define GFC_SPACE_RESET     6'h21
`define GFC_SEVENTH_END     4'hF
`define GFC_NO_SLOT         3'h0

`endif

// ==== pkg/gfc_pkg.sv ====
package gfc_pkg;

  typedef enum logic [2:0] {
    GFC_ST_IDLE = 3'b001,
    GFC_ST_REQ  = 3'b010,
    GFC_ST_WAIT = 3'b100
  } gfc_state_t;

endpackage : gfc_pkg

// ==== verilog/gfc_regs.sv ====
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`include "gfc_params.svh"
//
// Contract
// RULE_01 - writing one to a send bit starts that FIFO; hardware clears the bit
// RULE_02 - written retry field sets the retransmission limit for that FIFO
// RULE_03 - read retry field returns retries used by last successful packet
// RULE_04 - three-bit slot field picks the GTS that FIFO transmits in
// RULE_05 - ack request bit sends frame expecting ack, retransmits; resets zero
// RULE_06 - per FIFO security enable selects secured transmission; off at reset
// RULE_07 - second FIFO has an identical control register at the next address
// RULE_08 - one register holds third GTS end (high) and second GTS end (low)
// RULE_09 - next register holds fifth GTS end (high) and fourth GTS end (low)
// RULE_10 - sixth GTS end in low nibble; upper nibble reserved, reads zero
// RULE_11 - seventh GTS end slot is fixed at fifteen, no register field
// RULE_12 - six-bit long spacing field in pending register, reset 0x21
// RULE_13 - software makes spacing plus rf settle time equal forty symbols
// RULE_14 - alternate bit set: the two FIFOs keep alternating during the CFP
// RULE_15 - alternate bit clear (reset): alternation stops after a failure
// RULE_16 - ack pending bit is copied into every acknowledgement frame sent
// RULE_17 - immediate wake enable bit selects immediate wake-up mode
// RULE_18 - host wakes device by writing register wake bit one then zero
// RULE_19 - software writes zero to reserved bits of end-slot and wake regs
// RULE_20 - per FIFO flag set when transmission fails for lack of slot time
// RULE_21 - per FIFO flag set on retry-exceeded failure, cleared on success
// RULE_22 - FIFO clock enable bit gates the GTS FIFOs; off at reset
// RULE_23 - triggered frame goes out only inside its assigned GTS window
module gfc_regs
  import gfc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cfp_active,
  input  wire logic [3:0]  current_slot,
  input  wire logic [3:0]  cfp_first_slot,
  input  wire logic [3:0]  gts_first_end_slot,
  input  wire logic        tx_accept,
  input  wire logic        tx_done,
  input  wire logic        tx_success,
  input  wire logic        tx_no_time,
  input  wire logic [1:0]  tx_retries_used,
  output logic             tx_req,
  output logic             tx_fifo_sel,
  output logic             tx_secure,
  output logic             tx_ack_request,
  output logic [1:0]       tx_retry_limit,
  output logic             ack_pending_flag,
  output logic [5:0]       long_spacing_symbols,
  output logic             immediate_wake_enable,
  output logic             register_wake_pulse,
  output logic             slot_fifo_clock_on
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [7:0]  idx;
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [7:0]  wbyte;

  assign idx    = paddr[9:2];
  assign access = psel & penable;
  // one wait state so read data can come straight from a flop
  assign wr_en  = access & pwrite & pready_q & mapped;
  assign wbyte  = pwdata[7:0];

  always_comb begin
    case (idx)
      `GFC_IDX_FIFO_A, `GFC_IDX_FIFO_B, `GFC_IDX_END_32,
      `GFC_IDX_END_54, `GFC_IDX_END_6, `GFC_IDX_PENDING,
      `GFC_IDX_WAKE, `GFC_IDX_STATUS, `GFC_IDX_CLOCK: begin
        mapped = (paddr[1:0] == 2'h0);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // shared configuration registers
  // ****************************************************************
  logic [3:0] end_second_q;
  logic [3:0] end_third_q;
  logic [3:0] end_fourth_q;
  logic [3:0] end_fifth_q;
  logic [3:0] end_sixth_q;
  logic [5:0] space_q;
  logic       alt_q;
  logic       ack_pending_flag_q;
  logic       imm_q;
  logic       register_wake_pulse_q;
  logic       clkon_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      end_second_q <= 4'h0;
      end_third_q  <= 4'h0;
      end_fourth_q <= 4'h0;
      end_fifth_q  <= 4'h0;
      end_sixth_q  <= 4'h0;
    end else if (wr_en) begin
      if (idx == `GFC_IDX_END_32) begin
        end_third_q  <= wbyte[7:4]; // RULE_08
        end_second_q <= wbyte[3:0]; // RULE_08
      end
      if (idx == `GFC_IDX_END_54) begin
        end_fifth_q  <= wbyte[7:4]; // RULE_09
        end_fourth_q <= wbyte[3:0]; // RULE_09
      end
      if (idx == `GFC_IDX_END_6) begin
        end_sixth_q <= wbyte[3:0]; // RULE_10
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      space_q <= `GFC_SPACE_RESET; // RULE_12
      alt_q   <= 1'b0;
      ack_pending_flag_q <= 1'b0;
    end else if (wr_en && idx == `GFC_IDX_PENDING) begin
      space_q <= wbyte[`GFC_SPACE_HI:`GFC_SPACE_LO]; // RULE_12
      alt_q   <= wbyte[`GFC_ALT_BIT];
      ack_pending_flag_q <= wbyte[`GFC_ACK_PENDING_FLAG_BIT]; // RULE_16
    end
  end

  // register wake follows the host's one-then-zero write sequence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      imm_q     <= 1'b0;
      register_wake_pulse_q <= 1'b0;
    end else if (wr_en && idx == `GFC_IDX_WAKE) begin
      imm_q     <= wbyte[`GFC_IMM_BIT]; // RULE_17
      register_wake_pulse_q <= wbyte[`GFC_REGISTER_WAKE_PULSE_BIT]; // RULE_18
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkon_q <= 1'b0; // RULE_22
    end else if (wr_en && idx == `GFC_IDX_CLOCK) begin
      clkon_q <= wbyte[`GFC_CLKON_BIT]; // RULE_22
    end
  end

  // ****************************************************************
  // slot windows
  // ****************************************************************
  function automatic logic [3:0] end_of(input logic [2:0] gts);
    case (gts)
      3'h1:    end_of = gts_first_end_slot;
      3'h2:    end_of = end_second_q;
      3'h3:    end_of = end_third_q;
      3'h4:    end_of = end_fourth_q;
      3'h5:    end_of = end_fifth_q;
      3'h6:    end_of = end_sixth_q;
      default: end_of = `GFC_SEVENTH_END; // RULE_11
    endcase
  endfunction : end_of

  function automatic logic in_window(input logic [2:0] gts);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = 5'h0;
    hi = 5'h0;
    if (gts == 3'h1) begin
      lo = {1'b0, cfp_first_slot};
    end else begin
      lo = {1'b0, end_of(gts - 3'h1)} + 5'h01;
    end
    hi = {1'b0, end_of(gts)};
    // slot zero of the select means the FIFO owns no slot
    in_window = (gts != `GFC_NO_SLOT) &&
                ({1'b0, current_slot} >= lo) &&
                ({1'b0, current_slot} <= hi);
  endfunction : in_window

  // ****************************************************************
  // per FIFO control and status
  // ****************************************************************
  gfc_state_t state_q;
  logic       sel_q;
  logic       last_q;
  logic       stop_q;
  logic       lock_q;
  logic       tx_req_q;
  logic [1:0] send_q;
  logic [1:0] ack_q;
  logic [1:0] sec_q;
  logic [1:0] limit_a_q;
  logic [1:0] limit_b_q;
  logic [1:0] used_a_q;
  logic [1:0] used_b_q;
  logic [2:0] slot_a_q;
  logic [2:0] slot_b_q;
  logic [1:0] fail_q;
  logic [1:0] notime_q;
  logic [1:0] elig;
  logic       done_ev;
  logic       win_a;
  logic       win_b;

  // a process, not an assign, so slot and end-slot changes retrigger it
  always_comb begin
    win_a = in_window(slot_a_q); // RULE_23
    win_b = in_window(slot_b_q); // RULE_23
  end

  assign done_ev = (state_q == GFC_ST_WAIT) & tx_done;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_fifo
      logic [7:0] my_idx;
      logic       wr_me;
      logic       taken;
      logic       ended;
      assign my_idx = (gi == 0) ? `GFC_IDX_FIFO_A : `GFC_IDX_FIFO_B; // RULE_07
      assign wr_me  = wr_en & (idx == my_idx);
      assign taken  = (state_q == GFC_ST_REQ) & tx_accept &
                      (sel_q == 1'(gi));
      assign ended  = done_ev & (sel_q == 1'(gi));

      // a fresh trigger in the accept cycle wins over the clear
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          send_q[gi] <= 1'b0;
        end else if (wr_me && wbyte[`GFC_SEND_BIT]) begin
          send_q[gi] <= 1'b1; // RULE_01
        end else if (taken) begin
          send_q[gi] <= 1'b0; // RULE_01
        end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          ack_q[gi] <= 1'b0; // RULE_05
          sec_q[gi] <= 1'b0; // RULE_06
        end else if (wr_me) begin
          ack_q[gi] <= wbyte[`GFC_ACK_BIT]; // RULE_05
          sec_q[gi] <= wbyte[`GFC_SEC_BIT]; // RULE_06
        end
      end

      // hardware sets and clears these, software only reads them
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          fail_q[gi]   <= 1'b0;
          notime_q[gi] <= 1'b0;
        end else if (ended) begin
          notime_q[gi] <= ~tx_success & tx_no_time; // RULE_20
          fail_q[gi]   <= ~tx_success & ~tx_no_time; // RULE_21
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limit_a_q <= 2'h0;
      slot_a_q  <= 3'h0;
    end else if (wr_en && idx == `GFC_IDX_FIFO_A) begin
      limit_a_q <= wbyte[`GFC_RETRY_HI:`GFC_RETRY_LO]; // RULE_02
      slot_a_q  <= wbyte[`GFC_SLOT_HI:`GFC_SLOT_LO]; // RULE_04
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limit_b_q <= 2'h0;
      slot_b_q  <= 3'h0;
    end else if (wr_en && idx == `GFC_IDX_FIFO_B) begin
      limit_b_q <= wbyte[`GFC_RETRY_HI:`GFC_RETRY_LO]; // RULE_07
      slot_b_q  <= wbyte[`GFC_SLOT_HI:`GFC_SLOT_LO]; // RULE_07
    end
  end

  // readback keeps the count of the last success only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      used_a_q <= 2'h0;
      used_b_q <= 2'h0;
    end else if (done_ev && tx_success) begin
      if (sel_q) begin
        used_b_q <= tx_retries_used; // RULE_03
      end else begin
        used_a_q <= tx_retries_used; // RULE_03
      end
    end
  end

  // ****************************************************************
  // slot sequencer
  // ****************************************************************
  // alternate bit set overrides any lockout left by an earlier failure
  assign elig[0] = send_q[0] & clkon_q & cfp_active & win_a & // RULE_22
                   (~stop_q | ~lock_q | alt_q); // RULE_14
  assign elig[1] = send_q[1] & clkon_q & cfp_active & win_b & // RULE_22
                   (~stop_q | lock_q | alt_q); // RULE_14

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= GFC_ST_IDLE;
      sel_q    <= 1'b0;
      tx_req_q <= 1'b0;
    end else begin
      case (state_q)
        GFC_ST_IDLE: begin
          if (elig != 2'b00) begin
            // both ready: serve the one not served last
            if (elig == 2'b11) begin
              sel_q <= ~last_q; // RULE_14
            end else begin
              sel_q <= elig[1];
            end
            tx_req_q <= 1'b1;
            state_q  <= GFC_ST_REQ;
          end
        end
        GFC_ST_REQ: begin
          if (tx_accept) begin
            tx_req_q <= 1'b0;
            state_q  <= GFC_ST_WAIT;
          end else if (!elig[sel_q]) begin
            // window closed before the engine took it: withdraw
            tx_req_q <= 1'b0; // RULE_23
            state_q  <= GFC_ST_IDLE;
          end
        end
        GFC_ST_WAIT: begin
          if (tx_done) begin
            state_q <= GFC_ST_IDLE;
          end
        end
        default: begin
          tx_req_q <= 1'b0;
          state_q  <= GFC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      stop_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (!cfp_active) begin
      stop_q <= 1'b0;
    end else if (done_ev) begin
      last_q <= sel_q;
      if (!tx_success && !alt_q && !stop_q) begin
        stop_q <= 1'b1; // RULE_15
        lock_q <= sel_q; // RULE_15
      end
    end
  end

  // ****************************************************************
  // read path and answer
  // ****************************************************************
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    case (idx)
      `GFC_IDX_FIFO_A: rbyte = {used_a_q, slot_a_q, ack_q[0], sec_q[0],
                                send_q[0]}; // RULE_03
      `GFC_IDX_FIFO_B: rbyte = {used_b_q, slot_b_q, ack_q[1], sec_q[1],
                                send_q[1]};
      `GFC_IDX_END_32:  rbyte = {end_third_q, end_second_q};
      `GFC_IDX_END_54:  rbyte = {end_fifth_q, end_fourth_q};
      `GFC_IDX_END_6:   rbyte = {4'h0, end_sixth_q}; // RULE_10
      `GFC_IDX_PENDING: rbyte = {space_q, alt_q, ack_pending_flag_q};
      `GFC_IDX_WAKE:    rbyte = {imm_q, register_wake_pulse_q, 6'h00};
      `GFC_IDX_STATUS:  rbyte = {3'h0, notime_q[1], notime_q[0],
                                 fail_q[1], fail_q[0], 1'b0};
      `GFC_IDX_CLOCK:   rbyte = {4'h0, clkon_q, 3'h0};
      default:          rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (access && !pready_q && !pwrite && mapped) begin
        prdata_q <= {24'h00_0000, rbyte};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic       tx_sec_q;
  logic       tx_ack_q;
  logic [1:0] tx_lim_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_sec_q <= 1'b0;
      tx_ack_q <= 1'b0;
      tx_lim_q <= 2'h0;
    end else begin
      tx_sec_q <= sel_q ? sec_q[1] : sec_q[0]; // RULE_06
      tx_ack_q <= sel_q ? ack_q[1] : ack_q[0]; // RULE_05
      tx_lim_q <= sel_q ? limit_b_q : limit_a_q; // RULE_02
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign tx_req                = tx_req_q;
  assign tx_fifo_sel           = sel_q;
  assign tx_secure             = tx_sec_q;
  assign tx_ack_request        = tx_ack_q;
  assign tx_retry_limit        = tx_lim_q;
  assign ack_pending_flag      = ack_pending_flag_q; // RULE_16
  assign long_spacing_symbols  = space_q;
  assign immediate_wake_enable = imm_q;
  assign register_wake_pulse   = register_wake_pulse_q;
  assign slot_fifo_clock_on    = clkon_q;

endmodule : gfc_regs

// ==== verification/gfc_regs_checker.sv ====
`timescale 1ns/10ps
`include "gfc_params.svh"
module gfc_regs_checker (
  input logic        clk_sys,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [9:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        cfp_active,
  input logic        tx_accept,
  input logic        tx_req,
  input logic        ack_pending_flag,
  input logic [5:0]  long_spacing_symbols,
  input logic        immediate_wake_enable,
  input logic        register_wake_pulse,
  input logic        slot_fifo_clock_on
);
  // ****************************************
  // write and read decode of the answer cycle
  // ****************************************
  wire [7:0] wb      = pwdata[7:0];
  wire       wr_ok   = psel && penable && pready && pwrite;
  wire       pend_wr = wr_ok && paddr == {`GFC_IDX_PENDING, 2'b00};
  wire       wake_wr = wr_ok && paddr == {`GFC_IDX_WAKE, 2'b00};
  wire       clk_wr  = wr_ok && paddr == {`GFC_IDX_CLOCK, 2'b00};
  wire       e6_rd   = pready && !pwrite && paddr == {`GFC_IDX_END_6, 2'b00};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  send_clear_a: assert property (tx_req && tx_accept |=> !tx_req)
    else $error("request still up after accept");
  pend_flag_a: assert property (pend_wr |=>
    ack_pending_flag == 1'($past(wb)))
    else $error("ack pending flag not as written");
  spacing_a: assert property (pend_wr |=>
    long_spacing_symbols == 6'($past(wb) >> 2))
    else $error("spacing output not as written");
  imm_wake_a: assert property (wake_wr |=>
    immediate_wake_enable == 1'($past(wb) >> 7))
    else $error("immediate wake not as written");
  reg_wake_a: assert property (wake_wr |=>
    register_wake_pulse == 1'($past(wb) >> 6))
    else $error("register wake not as written");
  clock_on_a: assert property (clk_wr |=>
    slot_fifo_clock_on == 1'($past(wb) >> 3))
    else $error("clock enable not as written");
  cfp_off_a: assert property (!cfp_active [*2] |-> !tx_req)
    else $error("request outside the free period");
  clk_gate_a: assert property (!slot_fifo_clock_on [*2] |-> !tx_req)
    else $error("request while fifo clock off");
  end6_rsv_a: assert property (e6_rd |-> prdata[7:4] == 4'h0)
    else $error("reserved nibble not zero");
  pready_one_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_a: assert property (pready && paddr == {8'h23, 2'b00} |->
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : gfc_regs_checker

bind gfc_regs gfc_regs_checker u_chk (.clk_sys, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfp_active,
  .tx_accept, .tx_req, .ack_pending_flag, .long_spacing_symbols,
  .immediate_wake_enable, .register_wake_pulse, .slot_fifo_clock_on);

// ==== verification/gfc_engine_model.sv ====
`timescale 1ns/10ps
module gfc_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       tx_req,
  input  wire logic [3:0] acc_wait,
  input  wire logic [3:0] run_wait,
  input  wire logic       ok,
  input  wire logic       no_time,
  input  wire logic [1:0] tries,
  output logic            tx_accept,
  output logic            tx_done,
  output logic            tx_success,
  output logic            tx_no_time,
  output logic [1:0]      tx_retries_used
);
  logic [1:0] st_q;
  logic [3:0] cnt_q;

  // qualifiers carry no meaning outside done, so show the inverse there
  assign tx_success      = tx_done ? ok : ~ok;
  assign tx_no_time      = tx_done ? no_time : ~no_time;
  assign tx_retries_used = tx_done ? tries : ~tries;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= 2'h0;
      cnt_q     <= 4'h0;
      tx_accept <= 1'b0;
      tx_done   <= 1'b0;
    end else begin
      tx_accept <= 1'b0;
      tx_done   <= 1'b0;
      case (st_q)
        2'h0: if (tx_req) begin
          st_q  <= 2'h1;
          cnt_q <= acc_wait;
        end
        2'h1: if (!tx_req) st_q <= 2'h0;
        else if (cnt_q == 4'h0) begin
          tx_accept <= 1'b1;
          st_q      <= 2'h2;
          cnt_q     <= run_wait;
        end else cnt_q <= cnt_q - 4'h1;
        default: if (cnt_q == 4'h0) begin
          tx_done <= 1'b1;
          st_q    <= 2'h0;
        end else cnt_q <= cnt_q - 4'h1;
      endcase
    end
  end
endmodule : gfc_engine_model

// ==== verification/gfc_regs_tb_top.sv ====
`timescale 1ns/10ps
`include "gfc_params.svh"
module gfc_regs_tb_top;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, tx_req, tx_fifo_sel, tx_secure;
  logic        tx_ack_request, ack_pending_flag, immediate_wake_enable;
  logic        register_wake_pulse, slot_fifo_clock_on;
  logic [1:0]  tx_retry_limit, tx_retries_used, eng_tries = 2'h0;
  logic [5:0]  long_spacing_symbols;
  logic        cfp_active = 0, eng_ok = 0, eng_nt = 0;
  logic        tx_accept, tx_done, tx_success, tx_no_time;
  logic [3:0]  current_slot = 4'h0;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  // write byte, expected read byte, per register
  logic [23:0] rows [8] = '{24'h1CEE2E, 24'h1D5616, 24'h1EA5A5,
    24'h1F5A5A, 24'h200C0C, 24'h217F7F, 24'h228080, 24'h260808};

  gfc_regs dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cfp_active, .current_slot,
    .cfp_first_slot(4'h1), .gts_first_end_slot(4'h3), .tx_accept,
    .tx_done, .tx_success, .tx_no_time, .tx_retries_used, .tx_req,
    .tx_fifo_sel, .tx_secure, .tx_ack_request, .tx_retry_limit,
    .ack_pending_flag, .long_spacing_symbols, .immediate_wake_enable,
    .register_wake_pulse, .slot_fifo_clock_on);
  gfc_engine_model u_eng (.clk_sys, .rst_n, .tx_req, .acc_wait(4'h4),
    .run_wait(4'h3), .ok(eng_ok), .no_time(eng_nt), .tries(eng_tries),
    .tx_accept, .tx_done, .tx_success, .tx_no_time, .tx_retries_used);

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] d, output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    chk(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    chk({e, r}, {25'h0, x});
  endtask : rdc

  task automatic wait_hi(input bit done);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((done ? tx_done : tx_req) !== 1'b1 && n < 40);
    chk(n < 40, 1'b1);
  endtask : wait_hi

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      seen |= tx_req;
    end
    chk(seen, 1'b0);
  endtask : quiet

  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    chk(ack_pending_flag, 1'b1);
    chk(long_spacing_symbols, 6'h1F);
    chk({immediate_wake_enable, slot_fifo_clock_on}, 2'b11);
    // second reset in mid-run
    rst_n <= 1'b0;
    @(posedge clk_sys);
    chk({ack_pending_flag, immediate_wake_enable, slot_fifo_clock_on}, 0);
    chk(long_spacing_symbols, 6'h21);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(`GFC_IDX_FIFO_A, 8'h00);
    rdc(`GFC_IDX_END_6, 8'h00);
    rdc(`GFC_IDX_PENDING, 8'h84);
    rdc(`GFC_IDX_CLOCK, 8'h00);
    apb(1'b1, 8'h23, 8'hFF, r, e);
    apb(1'b0, 8'h23, 8'h00, r, e);
    chk({e, r}, {1'b1, 32'h0});
    // fifo a in its slot, clock gated off first
    cfp_active <= 1'b1;
    current_slot <= 4'h2;
    {eng_ok, eng_nt, eng_tries} <= 4'b1010;
    wr(`GFC_IDX_END_32, 8'h85);
    wr(`GFC_IDX_FIFO_A, 8'h8F);
    quiet(8);
    wr(`GFC_IDX_CLOCK, 8'h08);
    wait_hi(1'b0);
    @(posedge clk_sys);
    chk({tx_fifo_sel, tx_secure, tx_ack_request, tx_retry_limit}, 5'h0E);
    wait_hi(1'b1);
    repeat (2) @(posedge clk_sys);
    rdc(`GFC_IDX_FIFO_A, 8'h8E);
    // fifo b waits for its own window, then fails for lack of time
    {eng_ok, eng_nt} <= 2'b01;
    wr(`GFC_IDX_FIFO_B, 8'h11);
    quiet(8);
    current_slot <= 4'h4;
    wait_hi(1'b0);
    chk(tx_fifo_sel, 1'b1);
    wait_hi(1'b1);
    repeat (2) @(posedge clk_sys);
    rdc(`GFC_IDX_STATUS, 8'h10);
    rdc(`GFC_IDX_FIFO_B, 8'h10);
    // no alternation after a failure until the free period ends
    current_slot <= 4'h2;
    {eng_ok, eng_nt} <= 2'b00;
    wr(`GFC_IDX_FIFO_A, 8'h09);
    quiet(8);
    cfp_active <= 1'b0;
    @(posedge clk_sys);
    cfp_active <= 1'b1;
    wait_hi(1'b0);
    wait_hi(1'b1);
    repeat (2) @(posedge clk_sys);
    rdc(`GFC_IDX_STATUS, 8'h12);
    // alternation kept on: b goes despite a's failure, success clears
    wr(`GFC_IDX_PENDING, 8'h86);
    chk(ack_pending_flag, 1'b0);
    eng_ok <= 1'b1;
    current_slot <= 4'h5;
    wr(`GFC_IDX_FIFO_B, 8'h11);
    wait_hi(1'b0);
    chk(tx_fifo_sel, 1'b1);
    wait_hi(1'b1);
    repeat (2) @(posedge clk_sys);
    rdc(`GFC_IDX_STATUS, 8'h02);
    wr(`GFC_IDX_WAKE, 8'h40);
    chk(register_wake_pulse, 1'b1);
    wr(`GFC_IDX_WAKE, 8'h00);
    chk(register_wake_pulse, 1'b0);
    tally_and_finish();
  end
endmodule : gfc_regs_tb_top
